// file: tep_pkg.sv
// Package with register map, field layout and constants of the event and pulse timer channel
package tep_pkg;

  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [3:0] TEP_ADDR_TIMER_VALUE = 4'h0;
  localparam logic [3:0] TEP_ADDR_MODE = 4'h4;
  localparam logic [3:0] TEP_ADDR_START = 4'h8;
  localparam logic [3:0] TEP_ADDR_PRESCALER = 4'hC;

  // ****************************************
  // Field layout and encodings
  // ****************************************
  typedef enum logic [1:0] {
    TEP_MODE_IDLE,
    TEP_MODE_EVENT,
    TEP_MODE_PERIOD,
    TEP_MODE_WIDTH
  } tep_mode_e;

  typedef enum logic [1:0] {
    TEP_CLK_UNDIVIDED,
    TEP_CLK_DIV8,
    TEP_CLK_SUBCLOCK_DIV32,
    TEP_CLK_PRESCALED
  } tep_clk_e;

  localparam logic [1:0] TEP_EDGE_FALLING = 2'h0;
  localparam logic [1:0] TEP_EDGE_RISING = 2'h1;
  localparam logic [1:0] TEP_EDGE_BOTH = 2'h2;

  // Mode register: [7:6] clock, [5] overflow flag, [4] source, [3:2] edge, [1:0] mode
  typedef struct packed {
    tep_clk_e clk_sel;
    logic overflow_flag;
    logic src_neighbour;
    logic [1:0] edge_sel;
    tep_mode_e mode;
  } tep_mode_s;

  localparam int TEP_MODE_OVF_BIT = 5;
  localparam tep_mode_s TEP_MODE_RESET = '{TEP_CLK_UNDIVIDED, 1'b0, 1'b0, TEP_EDGE_FALLING,
                                           TEP_MODE_IDLE};
  localparam logic [15:0] TEP_COUNT_RESET = 16'h0000;
  localparam logic [15:0] TEP_COUNT_MAX = 16'hFFFF;
  localparam logic [3:0] TEP_PRESCALE_RESET = 4'h0;
  localparam logic [2:0] TEP_DIV8_LAST = 3'h7;

endpackage

// file: tep_timer_channel.sv
// Event counting and pulse period/width measuring timer channel with Avalon-MM slave
`timescale 1ns/1ps
module tep_timer_channel (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pulse_input_pin,
  input wire logic neighbour_channel,
  input wire logic subclock_div32,
  output logic irq_req,
  output logic underflow_out
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic edge_hit(input logic prev, input logic cur, input logic [1:0] sel);
    if (sel == tep_pkg::TEP_EDGE_RISING) begin
      edge_hit = !prev && cur;
    end else if (sel == tep_pkg::TEP_EDGE_BOTH) begin
      edge_hit = prev != cur;
    end else begin
      edge_hit = prev && !cur;
    end
  endfunction

  // ****************************************
  // Avalon-MM slave handshake
  // ****************************************
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic wr_fire;
  logic [15:0] wdata16;

  tep_pkg::tep_mode_s mode_r;
  tep_pkg::tep_mode_s mode_nxt;
  logic start_r;
  logic start_nxt;
  logic [3:0] psc_r;
  logic [3:0] psc_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] reload_r;
  logic [15:0] reload_nxt;
  logic seen_r;
  logic seen_nxt;
  logic pin_prev_r;
  logic irq_r;
  logic irq_nxt;
  logic uf_r;
  logic uf_nxt;

  // One wait cycle per access; read data is formed in the wait cycle so it is a flop
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_fire = avs_write && ack_r;
  assign wdata16 = avs_writedata[15:0];
  assign avs_readdata = rdata_r;

  always_comb begin
    ack_nxt = (avs_read || avs_write) && !ack_r;
    rdata_nxt = rdata_r;
    if (avs_read && !ack_r) begin
      if (avs_address == tep_pkg::TEP_ADDR_TIMER_VALUE) begin
        if (mode_r.mode == tep_pkg::TEP_MODE_EVENT) begin
          rdata_nxt = {16'h0000, cnt_r};
        end else begin
          rdata_nxt = {16'h0000, reload_r};
        end
      end else if (avs_address == tep_pkg::TEP_ADDR_MODE) begin
        rdata_nxt = {24'h000000, mode_r};
      end else if (avs_address == tep_pkg::TEP_ADDR_START) begin
        rdata_nxt = {31'h00000000, start_r};
      end else if (avs_address == tep_pkg::TEP_ADDR_PRESCALER) begin
        rdata_nxt = {28'h0000000, psc_r};
      end else begin
        rdata_nxt = 32'h00000000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ****************************************
  // Count clock dividers
  // ****************************************
  logic [2:0] div8_r;
  logic [2:0] div8_nxt;
  logic [4:0] pdiv_r;
  logic [4:0] pdiv_nxt;
  logic tick_div8;
  logic tick_psc;
  logic tick;

  assign tick_div8 = (div8_r == tep_pkg::TEP_DIV8_LAST);
  // Prescaler runs free, so the first prescaled tick after start may come early
  assign tick_psc = (psc_r == 4'h0) || (pdiv_r == 5'({psc_r, 1'b0} - 5'h01));

  always_comb begin
    div8_nxt = 3'(div8_r + 3'h1);
    pdiv_nxt = tick_psc ? 5'h00 : 5'(pdiv_r + 5'h01);
    case (mode_r.clk_sel)
      tep_pkg::TEP_CLK_UNDIVIDED: tick = 1'b1;
      tep_pkg::TEP_CLK_DIV8: tick = tick_div8;
      tep_pkg::TEP_CLK_SUBCLOCK_DIV32: tick = subclock_div32;
      default: tick = tick_psc;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      div8_r <= 3'h0;
      pdiv_r <= 5'h00;
    end else begin
      div8_r <= div8_nxt;
      pdiv_r <= pdiv_nxt;
    end
  end

  // ****************************************
  // Counter core
  // ****************************************
  logic ev_hit;
  logic cap_hit;
  logic measuring;

  assign measuring = (mode_r.mode == tep_pkg::TEP_MODE_PERIOD) ||
                     (mode_r.mode == tep_pkg::TEP_MODE_WIDTH);
  assign ev_hit = mode_r.src_neighbour ? neighbour_channel :
                  edge_hit(pin_prev_r, pulse_input_pin, mode_r.edge_sel);
  assign cap_hit = (mode_r.mode == tep_pkg::TEP_MODE_WIDTH) ?
                   edge_hit(pin_prev_r, pulse_input_pin, tep_pkg::TEP_EDGE_BOTH) :
                   edge_hit(pin_prev_r, pulse_input_pin, {1'b0, mode_r.edge_sel[0]});

  always_comb begin
    mode_nxt = mode_r;
    start_nxt = start_r;
    psc_nxt = psc_r;
    cnt_nxt = cnt_r;
    reload_nxt = reload_r;
    seen_nxt = seen_r;
    irq_nxt = 1'b0;
    uf_nxt = 1'b0;
    // Software writes first, so a hardware set in the same cycle wins
    if (wr_fire) begin
      if (avs_address == tep_pkg::TEP_ADDR_MODE) begin
        mode_nxt = tep_pkg::tep_mode_s'(avs_writedata[7:0]);
        mode_nxt.overflow_flag = mode_r.overflow_flag && avs_writedata[tep_pkg::TEP_MODE_OVF_BIT];
      end else if (avs_address == tep_pkg::TEP_ADDR_START) begin
        start_nxt = avs_writedata[0];
        if (avs_writedata[0] && !start_r) begin
          seen_nxt = 1'b0;
        end
      end else if (avs_address == tep_pkg::TEP_ADDR_PRESCALER) begin
        psc_nxt = avs_writedata[3:0];
      end else if (avs_address == tep_pkg::TEP_ADDR_TIMER_VALUE) begin
        if (mode_r.mode == tep_pkg::TEP_MODE_EVENT) begin
          reload_nxt = wdata16;
          if (!start_r) begin
            cnt_nxt = wdata16;
          end
        end
        // Measuring modes drop the write
      end
    end
    if (start_r) begin
      if (mode_r.mode == tep_pkg::TEP_MODE_EVENT) begin
        if (ev_hit) begin
          if (cnt_r == tep_pkg::TEP_COUNT_RESET) begin
            cnt_nxt = reload_nxt;
            irq_nxt = 1'b1;
            uf_nxt = 1'b1;
          end else begin
            cnt_nxt = 16'(cnt_r - 16'h0001);
          end
        end
      end else if (measuring) begin
        if (cap_hit) begin
          reload_nxt = cnt_r;
          cnt_nxt = tep_pkg::TEP_COUNT_RESET;
          irq_nxt = seen_r;
          seen_nxt = 1'b1;
        end else if (tick) begin
          if (cnt_r == tep_pkg::TEP_COUNT_MAX) begin
            cnt_nxt = tep_pkg::TEP_COUNT_RESET;
            mode_nxt.overflow_flag = 1'b1;
            irq_nxt = 1'b1;
          end else begin
            cnt_nxt = 16'(cnt_r + 16'h0001);
          end
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_r <= tep_pkg::TEP_MODE_RESET;
      start_r <= 1'b0;
      psc_r <= tep_pkg::TEP_PRESCALE_RESET;
      cnt_r <= tep_pkg::TEP_COUNT_RESET;
      reload_r <= tep_pkg::TEP_COUNT_RESET;
      seen_r <= 1'b0;
      pin_prev_r <= 1'b0;
      irq_r <= 1'b0;
      uf_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      start_r <= start_nxt;
      psc_r <= psc_nxt;
      cnt_r <= cnt_nxt;
      reload_r <= reload_nxt;
      seen_r <= seen_nxt;
      pin_prev_r <= pulse_input_pin;
      irq_r <= irq_nxt;
      uf_r <= uf_nxt;
    end
  end

  assign irq_req = irq_r;
  assign underflow_out = uf_r;

  // ****************************************
  // Assertions
  // ****************************************
  logic ev_run;
  logic tv_wr;

  assign ev_run = start_r && (mode_r.mode == tep_pkg::TEP_MODE_EVENT);
  assign tv_wr = wr_fire && (avs_address == tep_pkg::TEP_ADDR_TIMER_VALUE);

  property p_event_dec;
    @(posedge mclk) disable iff (rst)
      ev_run && ev_hit && (cnt_r != 16'h0000) && !tv_wr |=> cnt_r == 16'($past(cnt_r) - 16'h0001);
  endproperty
  a_event_dec: assert property (p_event_dec) else $error("event count did not decrement");

  property p_underflow_reload;
    @(posedge mclk) disable iff (rst)
      uf_r |-> (cnt_r == reload_r) && irq_r && ($past(cnt_r) == 16'h0000);
  endproperty
  a_underflow_reload: assert property (p_underflow_reload) else $error("bad reload");

  property p_underflow_irq;
    @(posedge mclk) disable iff (rst)
      ev_run && ev_hit && (cnt_r == 16'h0000) |=> irq_r && uf_r;
  endproperty
  a_underflow_irq: assert property (p_underflow_irq) else $error("underflow without irq");

  property p_stopped_hold;
    @(posedge mclk) disable iff (rst)
      !start_r && !wr_fire |=> $stable(cnt_r) && !irq_r;
  endproperty
  a_stopped_hold: assert property (p_stopped_hold) else $error("stopped channel moved");

  property p_stopped_write;
    @(posedge mclk) disable iff (rst)
      tv_wr && !start_r && (mode_r.mode == tep_pkg::TEP_MODE_EVENT)
      |=> (cnt_r == $past(wdata16)) && (reload_r == $past(wdata16));
  endproperty
  a_stopped_write: assert property (p_stopped_write) else $error("stopped write lost");

  property p_running_write;
    @(posedge mclk) disable iff (rst)
      tv_wr && ev_run && !ev_hit |=> (reload_r == $past(wdata16)) && $stable(cnt_r);
  endproperty
  a_running_write: assert property (p_running_write) else $error("running write wrong");

  property p_capture;
    @(posedge mclk) disable iff (rst)
      start_r && measuring && cap_hit |=> (cnt_r == 16'h0000) && (reload_r == $past(cnt_r));
  endproperty
  a_capture: assert property (p_capture) else $error("capture failed");

  property p_first_edge;
    @(posedge mclk) disable iff (rst)
      start_r && measuring && cap_hit |=> irq_r == $past(seen_r);
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("first edge irq wrong");

  property p_overflow;
    @(posedge mclk) disable iff (rst)
      start_r && measuring && !cap_hit && tick && (cnt_r == 16'hFFFF)
      |=> mode_r.overflow_flag && irq_r && (cnt_r == 16'h0000);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged");

  property p_measure_nowrite;
    @(posedge mclk) disable iff (rst)
      tv_wr && measuring && !(start_r && cap_hit) |=> $stable(reload_r);
  endproperty
  a_measure_nowrite: assert property (p_measure_nowrite) else $error("measure write taken");

  property p_read_value;
    @(posedge mclk) disable iff (rst)
      avs_read && !ack_r && (avs_address == tep_pkg::TEP_ADDR_TIMER_VALUE)
      |=> avs_readdata[15:0] ==
          $past((mode_r.mode == tep_pkg::TEP_MODE_EVENT) ? cnt_r : reload_r);
  endproperty
  a_read_value: assert property (p_read_value) else $error("timer read wrong");

  c_underflow: cover property (@(posedge mclk) disable iff (rst) uf_r);
  c_capture_irq: cover property (@(posedge mclk) disable iff (rst) measuring && irq_r);
  c_overflow: cover property (@(posedge mclk) disable iff (rst) $rose(mode_r.overflow_flag));

endmodule

// file: tep_pulse_src.sv
// Behavioural pulse source and neighbour channel model for the timer channel
`timescale 1ns/1ps
module tep_pulse_src (
  input wire logic mclk,
  output logic pin,
  output logic nb,
  output logic sub_tick
);
  logic [4:0] div_r = 5'h00;
  initial begin
    pin = 1'b0;
    nb = 1'b0;
    sub_tick = 1'b0;
  end
  // ****************************************
  // Free running subclock tick
  // ****************************************
  always @(posedge mclk) begin
    div_r <= div_r + 5'h01;
    sub_tick <= (div_r == 5'h1F);
  end
  // ****************************************
  // Pin pulses and neighbour events
  // ****************************************
  // Pin rests low so every pulse gives one rise and one fall
  task burst(input int n, input int h);
    repeat (n) begin
      repeat (h) @(posedge mclk);
      pin <= 1'b1;
      repeat (h) @(posedge mclk);
      pin <= 1'b0;
    end
    repeat (h) @(posedge mclk);
  endtask
  // One single-cycle pulse per neighbour wrap
  task nb_pulses(input int n);
    repeat (n) begin
      @(posedge mclk);
      nb <= 1'b1;
      @(posedge mclk);
      nb <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
endmodule

// file: tep_timer_channel_bench.sv
// Self-checking bench for the event and pulse timer channel
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tep_timer_channel_bench;
  localparam logic [3:0] TV = tep_pkg::TEP_ADDR_TIMER_VALUE;
  localparam logic [3:0] MD = tep_pkg::TEP_ADDR_MODE;
  localparam logic [3:0] ST = tep_pkg::TEP_ADDR_START;
  localparam logic [3:0] PS = tep_pkg::TEP_ADDR_PRESCALER;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata, q;
  logic wait_req, irq, ufl, pin, nb, sub;
  int err_count = 0;
  int tests_run = 0;
  int irqs = 0;
  int cyc = 0;
  int i0;
  int ufs = 0;
  int u0;
  always #12.5 mclk = ~mclk;
  tep_timer_channel tep_timer_channel_inst (.mclk(mclk), .rst(rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .pulse_input_pin(pin), .neighbour_channel(nb),
    .subclock_div32(sub), .irq_req(irq), .underflow_out(ufl));
  tep_pulse_src tep_pulse_src_inst (.mclk(mclk), .pin(pin), .nb(nb), .sub_tick(sub));
  // ****************************************
  // Watchdog, interrupt tally and bus master
  // ****************************************
  always @(posedge mclk) begin
    cyc++;
    if (irq === 1'b1) irqs++;
    if (ufl === 1'b1) ufs++;
    if (cyc == 90000) begin
      err_count++;
      stop_test();
    end
  end
  task stop_test;
    if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr <= w;
    rd <= ~w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge mclk);
    end while (wait_req !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task rdr(input logic [3:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task wt(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // Extra cycles after the start write pass before the interrupt and underflow tallies are sampled
  task go;
    wt(ST, 32'h1);
    repeat (2) @(posedge mclk);
    i0 = irqs;
    u0 = ufs;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    rdr(TV);
    `CHK(q, 32'h0)
    rdr(MD);
    `CHK(q, 32'h0)
    wt(PS, 32'hF);
    rdr(PS);
    `CHK(q, 32'hF)
    wt(4'h2, 32'hFFFF);
    rdr(4'h2);
    `CHK(q, 32'h0)
  endtask
  task t_event;
    wt(MD, 32'h01);
    wt(TV, 32'h2);
    rdr(TV);
    `CHK(q, 32'h2)
    go();
    tep_pulse_src_inst.burst(3, 4);
    `CHK(irqs - i0, 1)
    rdr(TV);
    `CHK(q, 32'h2)
    tep_pulse_src_inst.burst(1, 4);
    rdr(TV);
    `CHK(q, 32'h1)
    wt(TV, 32'h5);
    rdr(TV);
    `CHK(q, 32'h1)
    tep_pulse_src_inst.burst(2, 4);
    `CHK(irqs - i0, 2)
    `CHK(ufs - u0, 2)
    rdr(TV);
    `CHK(q, 32'h5)
    wt(MD, 32'h09);
    tep_pulse_src_inst.burst(1, 4);
    rdr(TV);
    `CHK(q, 32'h3)
    wt(ST, 32'h0);
    tep_pulse_src_inst.burst(2, 4);
    rdr(TV);
    `CHK(q, 32'h3)
  endtask
  task t_neigh;
    wt(MD, 32'h11);
    wt(TV, 32'h0);
    go();
    tep_pulse_src_inst.nb_pulses(4);
    repeat (3) @(posedge mclk);
    `CHK(irqs - i0, 4)
    `CHK(ufs - u0, 4)
    wt(ST, 32'h0);
  endtask
  task t_measure;
    wt(MD, 32'h06);
    go();
    tep_pulse_src_inst.burst(3, 10);
    `CHK(irqs - i0, 2)
    rdr(TV);
    `CHK(q, 32'h13)
    wt(TV, 32'h7);
    rdr(TV);
    `CHK(q, 32'h13)
    wt(ST, 32'h0);
    wt(MD, 32'h03);
    go();
    tep_pulse_src_inst.burst(2, 6);
    `CHK(irqs - i0, 3)
    `CHK(ufs - u0, 0)
    rdr(TV);
    `CHK(q, 32'h5)
    wt(ST, 32'h0);
    // Divide-by-8 tick phase against the capture edge shifts the count by one
    wt(MD, 32'h46);
    go();
    tep_pulse_src_inst.burst(2, 40);
    rdr(TV);
    `CHK((q == 32'h9) || (q == 32'hA), 1'b1)
    wt(ST, 32'h0);
  endtask
  // Undivided clock: exactly one wrap fits in the wait
  task t_ovf;
    wt(MD, 32'h06);
    go();
    repeat (65540) @(posedge mclk);
    rdr(MD);
    `CHK(q[tep_pkg::TEP_MODE_OVF_BIT], 1'b1)
    `CHK(irqs - i0, 1)
    wt(MD, 32'h06);
    rdr(MD);
    `CHK(q[tep_pkg::TEP_MODE_OVF_BIT], 1'b0)
    wt(ST, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_event();
    t_neigh();
    t_measure();
    t_ovf();
    stop_test();
  end
endmodule
